// ---- tsfc_consts.svh ----
// Purpose: timing counts and constants for the two-step conversion host controller
// Assumes: 200 MHz clock, period 5 ns
// Notes: times in ns except TSFC_START_LOW_MAX_US in us; cycle counts derived by expression except the timeout and pin-settle counts
`ifndef TSFC_CONSTS_SVH
`define TSFC_CONSTS_SVH
`define TSFC_CLK_PERIOD_NS 5
`define TSFC_START_LOW_MIN_NS 600
`define TSFC_START_LOW_CYC ((`TSFC_START_LOW_MIN_NS + `TSFC_CLK_PERIOD_NS - 1) / `TSFC_CLK_PERIOD_NS)
`define TSFC_READ_DELAY_MIN_NS 600
`define TSFC_READ_DELAY_CYC ((`TSFC_READ_DELAY_MIN_NS + `TSFC_CLK_PERIOD_NS - 1) / `TSFC_CLK_PERIOD_NS)
`define TSFC_START_LOW_MAX_US 50
`define TSFC_START_LOW_MAX_CYC ((`TSFC_START_LOW_MAX_US * 1000) / `TSFC_CLK_PERIOD_NS)
`define TSFC_RECOVER_MIN_NS 500
`define TSFC_RECOVER_CYC ((`TSFC_RECOVER_MIN_NS + `TSFC_CLK_PERIOD_NS - 1) / `TSFC_CLK_PERIOD_NS)
`define TSFC_CONV_TYP_NS 800
`define TSFC_CONV_TYP_CYC (`TSFC_CONV_TYP_NS / `TSFC_CLK_PERIOD_NS)
`define TSFC_RO_TIMEOUT_CYC 2000
`define TSFC_PIN_SETTLE_CYC 1
`define TSFC_CNT_W 14
`define TSFC_DATA_W 8
`endif

// ---- tsfc_dev_model.sv ----
// Purpose: behavioural converter on the far side of the host
// Assumes: strobes seen on clk_in edges; answers one cycle after a strobe edge
// Notes: undriven data shows the inverted byte so a stale value never looks valid
`timescale 1ns/10ps
`default_nettype none
module tsfc_dev_model
  import tsfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic mode_in,
  input wire logic [7:0] sample_in,
  input wire tsfc_strobes_t pins_in,
  output tsfc_dev_out_t dev_out
);
  tsfc_strobes_t last_reg = 3'h7;
  logic [8:0] cnt_reg = 9'h000;
  logic done_n_reg = 1'b0; // Low is the harsher power-up level
  logic rdy_reg = 1'b1;
  logic [7:0] held_reg = 8'h00;
  always_ff @(posedge clk_in) begin
    last_reg <= pins_in;
    if (cnt_reg != 9'h000) cnt_reg <= cnt_reg - 9'h001;
    if (cnt_reg == 9'h001) begin
      done_n_reg <= 1'b0;
      rdy_reg <= 1'b1;
    end
    if (mode_in && pins_in.conversion_start_strobe_n && !last_reg.conversion_start_strobe_n) begin
      held_reg <= sample_in;
      done_n_reg <= 1'b1;
      cnt_reg <= 9'h0A0;
    end
    if (last_reg.read_strobe_n && !pins_in.read_strobe_n) begin
      done_n_reg <= !mode_in;
      cnt_reg <= mode_in ? 9'h000 : 9'h140;
      rdy_reg <= mode_in;
      if (!mode_in) held_reg <= sample_in;
    end
    if (pins_in.read_strobe_n && !last_reg.read_strobe_n) done_n_reg <= 1'b1;
  end
  assign dev_out = {(pins_in.read_strobe_n || done_n_reg) ? ~held_reg : held_reg, done_n_reg, rdy_reg};
endmodule
`default_nettype wire

// ---- tsfc_host.sv ----
// Purpose: host controller that drives a clockless two-step flash converter
// Assumes: device pins sampled synchronously to clk_in; mode strap static
// Notes: one conversion per request; result returned with a one-cycle valid pulse
// Operation
// - Start-then-read conversion begins by pulling the start strobe low.
// - Start strobe stays low at least 600 ns; rising edge latches upper nibble.
// - Read strobe falls at least 600 ns after start strobe rises.
// - Read-only conversion holds read strobe low until data appears.
// - Start-then-read: host reads after done falls or after minimum delay.
// - Early read after 600 ns makes done fall at once with data.
// - Stand-alone: select and read held low, data valid 800 ns after start; this host has no stand-alone mode.
// - Start strobe never held low longer than 50 microseconds.
// - Wait at least 500 ns after a conversion before the next.
`timescale 1ns/10ps
`default_nettype none
`include "tsfc_consts.svh"
module tsfc_host
  import tsfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic mode_strap_in,
  input wire logic early_read_in,
  input wire logic conv_req_in,
  input wire tsfc_dev_out_t dev_in,
  output tsfc_strobes_t strobes_out,
  output logic busy_out,
  output logic [`TSFC_DATA_W-1:0] result_out,
  output logic result_valid_out,
  output logic timeout_out
);
  typedef enum logic [2:0] {
    TSFC_IDLE, TSFC_START_LOW, TSFC_WAIT_READ, TSFC_READ_LOW, TSFC_RECOVER
  } tsfc_state_t;

  tsfc_state_t state_reg;
  tsfc_mode_t mode_reg;
  logic early_reg;
  logic [`TSFC_CNT_W-1:0] cnt_reg;
  logic cs_n_reg, start_n_reg, rd_n_reg;
  logic [`TSFC_DATA_W-1:0] result_reg;
  logic valid_reg, timeout_reg, busy_reg;
  logic done_seen;
  logic read_done;

  // Done is used once the minimum read delay has passed in TSFC_WAIT_READ, and after the read strobe settles in TSFC_READ_LOW; its power-up level means nothing
  assign done_seen = ~dev_in.conversion_done_n;

  // ------------------------------------------------------------
  // Read completion
  // ------------------------------------------------------------
  // The read strobe reaches the pin a cycle after the sequencer lowers it, and done may
  // still carry its power-up or previous level; an answer counts only once the pin has
  // been low long enough for the device to have reacted
  always_comb begin
    read_done = 1'b0;
    if (state_reg == TSFC_READ_LOW && cnt_reg > `TSFC_CNT_W'(`TSFC_PIN_SETTLE_CYC)) begin
      unique case (mode_reg)
        TSFC_READ_ONLY: begin
          // Ready alone is not enough: it stands high between conversions
          read_done = done_seen && dev_in.ready;
        end
        TSFC_START_THEN_READ: begin
          read_done = done_seen;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Mode capture
  // ------------------------------------------------------------
  // Strap is taken when a request is accepted in idle, so it is never changed mid-conversion
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      mode_reg <= TSFC_READ_ONLY;
      early_reg <= 1'b0;
    end else if (state_reg == TSFC_IDLE && conv_req_in) begin
      mode_reg <= mode_strap_in ? TSFC_START_THEN_READ : TSFC_READ_ONLY;
      early_reg <= early_read_in;
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= TSFC_IDLE;
      cnt_reg <= '0;
      cs_n_reg <= 1'b1;
      start_n_reg <= 1'b1;
      rd_n_reg <= 1'b1;
      busy_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        TSFC_IDLE: begin
          cnt_reg <= '0;
          if (conv_req_in) begin
            busy_reg <= 1'b1;
            cs_n_reg <= 1'b0;
            if (mode_strap_in) begin
              start_n_reg <= 1'b0;
              state_reg <= TSFC_START_LOW;
            end else begin
              rd_n_reg <= 1'b0;
              state_reg <= TSFC_READ_LOW;
            end
          end
        end
        TSFC_START_LOW: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Exactly the minimum width, far inside the 50 us ceiling
          if (cnt_reg == `TSFC_CNT_W'(`TSFC_START_LOW_CYC - 1)) begin
            start_n_reg <= 1'b1;
            cnt_reg <= '0;
            state_reg <= TSFC_WAIT_READ;
          end
        end
        TSFC_WAIT_READ: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Early read after the minimum gap, otherwise wait for done
          if ((early_reg && cnt_reg >= `TSFC_CNT_W'(`TSFC_READ_DELAY_CYC - 1)) ||
              (!early_reg && cnt_reg >= `TSFC_CNT_W'(`TSFC_READ_DELAY_CYC - 1) && done_seen)) begin
            rd_n_reg <= 1'b0;
            cnt_reg <= '0;
            state_reg <= TSFC_READ_LOW;
          end else if (cnt_reg == `TSFC_CNT_W'(`TSFC_RO_TIMEOUT_CYC)) begin
            rd_n_reg <= 1'b0;
            cnt_reg <= '0;
            state_reg <= TSFC_READ_LOW;
          end
        end
        TSFC_READ_LOW: begin
          cnt_reg <= cnt_reg + 1'b1;
          // Read-only: hold until done and ready show completion; start-then-read: done is immediate
          if (read_done || cnt_reg == `TSFC_CNT_W'(`TSFC_RO_TIMEOUT_CYC)) begin
            rd_n_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            cnt_reg <= '0;
            state_reg <= TSFC_RECOVER;
          end
        end
        TSFC_RECOVER: begin
          cnt_reg <= cnt_reg + 1'b1;
          if (cnt_reg == `TSFC_CNT_W'(`TSFC_RECOVER_CYC - 1)) begin
            busy_reg <= 1'b0;
            cnt_reg <= '0;
            state_reg <= TSFC_IDLE;
          end
        end
        default: state_reg <= TSFC_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Result capture
  // ------------------------------------------------------------
  // Data is sampled while read is still low, before the device floats its outputs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_reg <= '0;
      valid_reg <= 1'b0;
      timeout_reg <= 1'b0;
    end else begin
      valid_reg <= 1'b0;
      if (state_reg == TSFC_IDLE && conv_req_in) begin
        timeout_reg <= 1'b0;
      end
      if (state_reg == TSFC_READ_LOW && cnt_reg == `TSFC_CNT_W'(`TSFC_RO_TIMEOUT_CYC)) begin
        timeout_reg <= 1'b1;
      end else if (state_reg == TSFC_WAIT_READ && cnt_reg == `TSFC_CNT_W'(`TSFC_RO_TIMEOUT_CYC)) begin
        timeout_reg <= 1'b1;
      end
      if (read_done) begin
        result_reg <= dev_in.data;
        valid_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin and output registers
  // ------------------------------------------------------------
  // Strobes leave through one more flop, so every pin edge lags the sequencer by a cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strobes_out <= '1;
    end else begin
      strobes_out <= '{chip_select_n: cs_n_reg, conversion_start_strobe_n: start_n_reg,
                       read_strobe_n: rd_n_reg};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_out <= 1'b0;
      result_out <= '0;
      result_valid_out <= 1'b0;
      timeout_out <= 1'b0;
    end else begin
      busy_out <= busy_reg;
      result_out <= result_reg;
      result_valid_out <= valid_reg;
      timeout_out <= timeout_reg;
    end
  end
endmodule
`default_nettype wire

// ---- tsfc_host_monitor.sv ----
// Purpose: port assertions for the conversion host controller
// Assumes: one clock domain, async active-high reset
// Notes: counts are 5 ns cycles; far-reaching counters never wrap within a run
`timescale 1ns/10ps
`default_nettype none
module tsfc_host_monitor
  import tsfc_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire tsfc_dev_out_t dev_in,
  input wire tsfc_strobes_t strobes_out,
  input wire logic [7:0] result_out,
  input wire logic result_valid_out
);
  int lo_cnt, rd_cnt, rise_cnt, gap_cnt;
  wire wr_n = strobes_out.conversion_start_strobe_n;
  wire rd_n = strobes_out.read_strobe_n;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Gap counters start large so the first request after reset is legal
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      lo_cnt <= 0;
      rd_cnt <= 0;
      rise_cnt <= 999;
      gap_cnt <= 999;
    end else begin
      lo_cnt <= wr_n ? 0 : lo_cnt + 1;
      rd_cnt <= rd_n ? 0 : rd_cnt + 1;
      rise_cnt <= wr_n ? rise_cnt + 1 : 0;
      gap_cnt <= rd_n ? gap_cnt + 1 : 0;
    end
  end
  sequence s_done_seen;
    !rd_n [*2] ##0 (!dev_in.conversion_done_n && dev_in.ready);
  endsequence
  a_start_min_width: assert property ($rose(wr_n) |-> lo_cnt >= 120)
    else $error("start too short");
  a_start_max_width: assert property (!wr_n |-> lo_cnt < 10000)
    else $error("start too long");
  a_read_after_start: assert property ($fell(rd_n) |-> rise_cnt >= 120)
    else $error("read too early");
  a_select_covers: assert property (!(wr_n && rd_n) |-> !strobes_out.chip_select_n)
    else $error("strobe without select");
  a_recovery_gap: assert property ($fell(strobes_out.chip_select_n) |-> gap_cnt >= 100)
    else $error("recovery too short");
  a_read_held: assert property (!rd_n && dev_in.conversion_done_n && rd_cnt < 1900 |=> !rd_n)
    else $error("read released early");
  a_done_to_result: assert property (s_done_seen |-> ##[1:4] result_valid_out)
    else $error("no result after done");
  a_result_holds: assert property (result_valid_out |=> $stable(result_out) [*8])
    else $error("result moved");
endmodule
bind tsfc_host tsfc_host_monitor mon (.clk_in, .rst_in, .dev_in, .strobes_out, .result_out, .result_valid_out);
`default_nettype wire

// ---- tsfc_host_tb.sv ----
// Purpose: self-checking bench for the conversion host controller
// Assumes: 200 MHz clock, seed 48
// Notes: a request is held until its result, since requests are ignored while busy
`timescale 1ns/10ps
`default_nettype none
module tsfc_host_tb;
  import tsfc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mode = 1'b0, early = 1'b0, req = 1'b0;
  logic busy, valid, tmo;
  logic [7:0] sample = 8'h00;
  logic [7:0] result;
  tsfc_strobes_t pins;
  tsfc_dev_out_t dev;
  int fail_count = 0, n_tests = 0, cyc = 0;
  always #2.5 clk_in = ~clk_in;
  tsfc_host DUT (.clk_in(clk_in), .rst_in(rst_in), .mode_strap_in(mode), .early_read_in(early), .conv_req_in(req),
    .dev_in(dev), .strobes_out(pins), .busy_out(busy), .result_out(result), .result_valid_out(valid), .timeout_out(tmo));
  tsfc_dev_model dev_model (.clk_in(clk_in), .mode_in(mode), .sample_in(sample), .pins_in(pins), .dev_out(dev));
  function automatic logic [7:0] expect_result(input logic [7:0] s);
    return {s[7:4], s[3:0]};
  endfunction
  task automatic check(input logic [12:0] seen, input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic convert(input logic m, input logic e, input logic [7:0] s);
    mode <= m;
    early <= e;
    sample <= s;
    req <= 1'b1;
    do @(posedge clk_in); while (valid !== 1'b1);
    req <= 1'b0;
    check({busy, tmo, pins, result}, {2'b10, 3'h7, expect_result(s)});
    @(posedge clk_in);
  endtask
  initial begin
    void'($urandom(48));
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    check({busy, tmo, pins, result}, 13'h0700);
    convert(1'b0, 1'b0, 8'h3C);
    convert(1'b1, 1'b1, 8'h00);
    convert(1'b1, 1'b0, 8'hFF);
    convert(1'b0, 1'b0, 8'hA5);
    for (int i = 0; i < 12; i++) convert(1'($urandom), 1'($urandom), 8'($urandom));
    end_of_test();
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
endmodule
`default_nettype wire

// ---- tsfc_pkg.sv ----
// Purpose: types for the two-step conversion host controller
// Assumes: included constants header
// Notes: none
`default_nettype none
`include "tsfc_consts.svh"
package tsfc_pkg;
  typedef enum logic {TSFC_READ_ONLY, TSFC_START_THEN_READ} tsfc_mode_t;
  typedef struct packed {
    logic chip_select_n;
    logic conversion_start_strobe_n;
    logic read_strobe_n;
  } tsfc_strobes_t;
  typedef struct packed {
    logic [`TSFC_DATA_W-1:0] data;
    logic conversion_done_n;
    logic ready;
  } tsfc_dev_out_t;
endpackage
`default_nettype wire
